// >>> rtl/optstat_pkg.sv
// Package: register map, field codes and timing for the option status block
package optstat_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_MODULE_TYPE = 8'h00;
    localparam logic [7:0] OFF_FW_MAJOR = 8'h04;
    localparam logic [7:0] OFF_FW_MINOR = 8'h08;
    localparam logic [7:0] OFF_NODE_ADDR = 8'h0C;
    localparam logic [7:0] OFF_RATE_SEL = 8'h10;
    localparam logic [7:0] OFF_FRAME_SEL = 8'h14;
    localparam logic [7:0] OFF_STATE_CODE = 8'h18;
    localparam logic [7:0] OFF_CONTROL = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_DATA_FORMAT = 8'h24;

    // ****************************************
    // Reset values and ranges
    // ****************************************
    localparam logic [7:0] RST_NODE_ADDR = 8'h01;
    localparam logic [3:0] RST_RATE_SEL = 4'h6;
    localparam logic [3:0] MAX_RATE_SEL = 4'h8;
    localparam logic [1:0] RST_FRAME_SEL = 2'h0;
    localparam logic [8:0] MAX_MODULE_TYPE = 9'h1F3;
    localparam logic [3:0] DEF_OUT_CHANNELS = 4'h2;
    localparam logic [3:0] DEF_IN_CHANNELS = 4'h2;
    localparam logic [3:0] MAX_CYCLIC_ITEMS = 4'hA;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTL_REINIT = 0;
    localparam int CTL_RESTART = 1;
    localparam int CTL_CONFIG_BAD = 2;
    localparam int CTL_DIAG_AVAIL = 3;
    localparam int CTL_TRIP_ENABLE = 4;

    // ****************************************
    // Operating state codes
    // ****************************************
    localparam logic [3:0] ST_SETUP = 4'h0;
    localparam logic [3:0] ST_NET_INIT = 4'h1;
    localparam logic [3:0] ST_PD_INACTIVE = 4'h2;
    localparam logic [3:0] ST_IDLE = 4'h3;
    localparam logic [3:0] ST_ACTIVE = 4'h4;
    localparam logic [3:0] ST_BUS_ERROR = 4'h5;
    localparam logic [3:0] ST_WAIT_DB = 4'h6;
    localparam logic [3:0] ST_HOST_ERROR = 4'h7;
    localparam logic [3:0] ST_OPT_LOSS = 4'h8;
    localparam logic [3:0] ST_SUPERVISED = 4'hC;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int FLASH_MS = 200;
    localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;

    typedef enum logic [1:0] {LAMP_OFF, LAMP_GREEN, LAMP_YELLOW, LAMP_RED} lamp_t;

    // Status from the module's network engine
    typedef struct packed {
        logic setup_busy;
        logic net_init;
        logic pd_inactive;
        logic idle;
        logic pd_active;
        logic bus_error;
        logic wait_db;
        logic host_error;
        logic option_loss;
        logic supervised;
        logic frame_busy;
        logic fatal_error;
        logic internal_fault;
    } net_status_t;

    // Serial link settings applied to the engine
    typedef struct packed {
        logic [7:0] node_addr;
        logic [16:0] baud;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
    } link_cfg_t;

endpackage : optstat_pkg

// >>> rtl/fieldbus_option_status_config.sv
// Register bank, state encoder and lamp drivers for the fieldbus option module
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

module fieldbus_option_status_config
    import optstat_pkg::*;
#(
    parameter logic [8:0] MODULE_TYPE = 9'h0AA,  // Arbitrary value
    parameter logic [15:0] FW_MAJOR = 16'h0000,
    parameter logic [7:0] FW_MINOR = 8'h00,
    parameter int FLASH_LEN = FLASH_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Network engine
    input wire net_status_t net_status,
    input wire logic mapping_error,
    output link_cfg_t link_cfg,
    output logic net_enable,
    output logic drive_trip,
    // Front panel lamps
    output lamp_t comm_lamp,
    output lamp_t status_lamp
);
    import optstat_pkg::*;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [16:0] rate_baud(input logic [3:0] code);
        case (code)
            4'h0: rate_baud = 17'd1200;
            4'h1: rate_baud = 17'd2400;
            4'h2: rate_baud = 17'd4800;
            4'h3: rate_baud = 17'd9600;
            4'h4: rate_baud = 17'd19200;
            4'h5: rate_baud = 17'd38400;
            4'h6: rate_baud = 17'd57600;
            4'h7: rate_baud = 17'd76800;
            default: rate_baud = 17'd115200;
        endcase
    endfunction : rate_baud

    // ****************************************
    // Registers and state
    // ****************************************
    logic [7:0] node_address_setting;
    logic [3:0] serial_rate_select;
    logic [1:0] parity_stop_select;
    logic [7:0] active_node;
    logic [3:0] active_rate;
    logic [1:0] active_frame;
    logic [3:0] operating_state_code;
    logic [3:0] next_state_code;
    logic host_error_latched;
    logic config_bad;
    logic diag_avail;
    logic trip_enable;
    logic reinit_pulse;
    logic restart_pulse;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic mismatch;

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Writable settings
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            node_address_setting <= RST_NODE_ADDR;
            serial_rate_select <= RST_RATE_SEL;
            parity_stop_select <= RST_FRAME_SEL;
            config_bad <= 1'b0;
            diag_avail <= 1'b0;
            trip_enable <= 1'b0;
        end
        else if (do_write && w_strb[0])
        begin
            case (aw_addr)
                OFF_NODE_ADDR: node_address_setting <= w_data[7:0];
                OFF_RATE_SEL:
                begin
                    if (w_data[7:0] <= {4'h0, MAX_RATE_SEL})
                        serial_rate_select <= w_data[3:0];
                end
                OFF_FRAME_SEL:
                begin
                    if (w_data[7:0] <= 8'h03)
                        parity_stop_select <= w_data[1:0];
                end
                OFF_CONTROL:
                begin
                    config_bad <= w_data[CTL_CONFIG_BAD];
                    diag_avail <= w_data[CTL_DIAG_AVAIL];
                    trip_enable <= w_data[CTL_TRIP_ENABLE];
                end
                default: ;
            endcase
        end
    end

    // Self-clearing command bits
    assign reinit_pulse = do_write && w_strb[0] && aw_addr == OFF_CONTROL && w_data[CTL_REINIT];
    assign restart_pulse = do_write && w_strb[0] && aw_addr == OFF_CONTROL
        && w_data[CTL_RESTART];

    // ****************************************
    // Settings in use; applied only on reinit or restart
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            active_node <= RST_NODE_ADDR;
            active_rate <= RST_RATE_SEL;
            active_frame <= RST_FRAME_SEL;
        end
        else if (reinit_pulse || restart_pulse)
        begin
            active_node <= node_address_setting;
            active_rate <= serial_rate_select;
            active_frame <= parity_stop_select;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            link_cfg <= '0;
        end
        else
        begin
            link_cfg.node_addr <= active_node;
            link_cfg.baud <= rate_baud(active_rate);
            link_cfg.parity_en <= active_frame[1];
            link_cfg.parity_odd <= active_frame == 2'h3;
            link_cfg.two_stop <= active_frame == 2'h0;
        end
    end

    // Stored settings that differ from those in use
    assign mismatch = node_address_setting != active_node
        || serial_rate_select != active_rate || parity_stop_select != active_frame;

    // ****************************************
    // Operating state
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            host_error_latched <= 1'b0;
        else if (net_status.host_error)
            host_error_latched <= 1'b1;
        else if (restart_pulse)
            host_error_latched <= 1'b0; // Set wins: a live host error survives restart
    end

    always_comb
    begin
        // Faults outrank progress states
        if (host_error_latched || net_status.host_error)
            next_state_code = ST_HOST_ERROR;
        else if (net_status.option_loss)
            next_state_code = ST_OPT_LOSS;
        else if (net_status.bus_error)
            next_state_code = ST_BUS_ERROR;
        else if (net_status.wait_db)
            next_state_code = ST_WAIT_DB;
        else if (net_status.setup_busy)
            next_state_code = ST_SETUP;
        else if (net_status.net_init)
            next_state_code = ST_NET_INIT;
        else if (net_status.pd_inactive)
            next_state_code = ST_PD_INACTIVE;
        else if (net_status.supervised)
            next_state_code = ST_SUPERVISED;
        else if (net_status.pd_active)
            next_state_code = ST_ACTIVE;
        else
            next_state_code = ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            operating_state_code <= ST_SETUP;
        else
            operating_state_code <= next_state_code;
    end

    // Host error stops all network participation
    assign net_enable = !host_error_latched;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            drive_trip <= 1'b0;
        else
            drive_trip <= trip_enable && (mapping_error || net_status.bus_error);
    end

    // ****************************************
    // Flash timing for the status lamp
    // ****************************************
    logic [31:0] flash_cnt;
    logic [2:0] phase;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flash_cnt <= 32'h0000_0000;
            phase <= 3'h0;
        end
        else if (flash_cnt >= 32'(FLASH_LEN - 1))
        begin
            flash_cnt <= 32'h0000_0000;
            phase <= phase + 3'h1;
        end
        else
        begin
            flash_cnt <= flash_cnt + 32'h0000_0001;
        end
    end

    // ****************************************
    // Lamps
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            comm_lamp <= LAMP_OFF;
            status_lamp <= LAMP_OFF;
        end
        else
        begin
            if (net_status.fatal_error)
                comm_lamp <= LAMP_RED;
            else if (net_status.frame_busy)
                comm_lamp <= LAMP_YELLOW;
            else
                comm_lamp <= LAMP_OFF;

            if (net_status.internal_fault || host_error_latched)
                status_lamp <= LAMP_RED;
            else if (config_bad || mismatch)
                status_lamp <= (phase == 3'h0) ? LAMP_RED : LAMP_OFF;
            else if (diag_avail)
                status_lamp <= (phase == 3'h0 || phase == 3'h2) ? LAMP_RED : LAMP_OFF;
            else if (operating_state_code == ST_SETUP)
                status_lamp <= LAMP_OFF;
            else
                status_lamp <= LAMP_GREEN;
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                OFF_MODULE_TYPE: s_axi_rdata <= {23'h0, (MODULE_TYPE > MAX_MODULE_TYPE)
                    ? MAX_MODULE_TYPE : MODULE_TYPE};
                OFF_FW_MAJOR: s_axi_rdata <= {16'h0, FW_MAJOR};
                OFF_FW_MINOR: s_axi_rdata <= {24'h0, FW_MINOR};
                OFF_NODE_ADDR: s_axi_rdata <= {24'h0, node_address_setting};
                OFF_RATE_SEL: s_axi_rdata <= {28'h0, serial_rate_select};
                OFF_FRAME_SEL: s_axi_rdata <= {30'h0, parity_stop_select};
                OFF_STATE_CODE: s_axi_rdata <= {28'h0, operating_state_code};
                OFF_CONTROL: s_axi_rdata <= {27'h0, trip_enable, diag_avail, config_bad,
                    2'h0};
                OFF_STATUS: s_axi_rdata <= {28'h0, drive_trip, mismatch,
                    host_error_latched, net_enable};
                OFF_DATA_FORMAT: s_axi_rdata <= {20'h0, MAX_CYCLIC_ITEMS,
                    DEF_IN_CHANNELS, DEF_OUT_CHANNELS};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : fieldbus_option_status_config

// >>> dv/optstat_checker.sv
// Port assertions for the option status block
`timescale 1ns/1ps
module optstat_checker
(
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Engine side and lamps
    input wire optstat_pkg::net_status_t net_status,
    input wire logic mapping_error,
    input wire optstat_pkg::link_cfg_t link_cfg,
    input wire logic net_enable,
    input wire logic drive_trip,
    input wire optstat_pkg::lamp_t comm_lamp,
    input wire optstat_pkg::lamp_t status_lamp
);
    import optstat_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    trip_quiet_a: assert property (
        !mapping_error && !net_status.bus_error |=> !drive_trip)
        else $error("trip without cause");
    fatal_red_a: assert property (
        net_status.fatal_error |=> comm_lamp == LAMP_RED)
        else $error("comm lamp not red");
    traffic_yellow_a: assert property (
        net_status.frame_busy && !net_status.fatal_error |=> comm_lamp == LAMP_YELLOW)
        else $error("comm lamp not yellow");
    fault_red_a: assert property (
        net_status.internal_fault |=> status_lamp == LAMP_RED)
        else $error("status lamp not red");
    host_stop_a: assert property (
        net_status.host_error |=> !net_enable)
        else $error("network kept on");
    host_hold_a: assert property (
        !net_enable && !s_axi_wvalid && !s_axi_awvalid && !$past(s_axi_wvalid)
        && !$past(s_axi_awvalid) |=> !net_enable)
        else $error("host error left alone");
    link_hold_a: assert property (
        $past(rst_n) && !s_axi_wvalid && !s_axi_awvalid && !s_axi_bvalid
        && !$past(s_axi_bvalid) |=> $stable(link_cfg))
        else $error("link settings moved");
endmodule : optstat_checker

bind fieldbus_option_status_config optstat_checker u_chk (.clk, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .net_status, .mapping_error, .link_cfg, .net_enable,
    .drive_trip, .comm_lamp, .status_lamp);

// >>> dv/net_engine_model.sv
// Network engine model: turns a requested state into status levels
`timescale 1ns/1ps
module net_engine_model
(
    // Requested behaviour
    input wire logic [3:0] mode,
    input wire logic [2:0] flags,
    input wire optstat_pkg::link_cfg_t link_cfg,
    // Levels toward the block
    output optstat_pkg::net_status_t net_status,
    output logic rate_match
);
    import optstat_pkg::*;
    // Master rate is fixed; any other rate means a dead link
    localparam int MASTER_BAUD = 57600;

    always_comb
    begin
        net_status = '0;
        net_status.setup_busy = (mode == 4'h0);
        net_status.net_init = (mode == 4'h1);
        net_status.pd_inactive = (mode == 4'h2);
        net_status.idle = (mode == 4'h3);
        net_status.pd_active = (mode == 4'h4);
        net_status.bus_error = (mode == 4'h5);
        net_status.wait_db = (mode == 4'h6);
        net_status.host_error = (mode == 4'h7);
        net_status.option_loss = (mode == 4'h8);
        net_status.supervised = (mode == 4'hC);
        net_status.frame_busy = flags[0];
        net_status.fatal_error = flags[1];
        net_status.internal_fault = flags[2];
    end

    assign rate_match = (int'(link_cfg.baud) == MASTER_BAUD);
endmodule : net_engine_model

// >>> dv/tb_top.sv
// Testbench for the option status and link settings block
`timescale 1ns/1ps
module tb_top;
    import optstat_pkg::*;
    localparam int FL = 4;
    logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, mode;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] flags;
    logic mapping_error, net_enable, drive_trip, rate_match;
    net_status_t net_status;
    link_cfg_t link_cfg;
    lamp_t comm_lamp, status_lamp;
    int fail_count, samples_checked, model[int];
    int baud_tab[9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
    int state_seq[9] = '{0, 1, 2, 3, 5, 6, 8, 12, 4};

    fieldbus_option_status_config #(.FLASH_LEN(FL)) DUT (.clk, .rst_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .net_status, .mapping_error, .link_cfg, .net_enable, .drive_trip,
        .comm_lamp, .status_lamp);
    net_engine_model engine (.mode, .flags, .link_cfg, .net_status, .rate_match);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****
    // Tasks
    // ****
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", w, e, g);
        end
    endtask : check

    task automatic guard(input int n);
        if (n > 60)
        begin
            fail_count++;
            $display("[ERR] handshake expected answer seen none");
            report_and_stop();
        end
    endtask : guard

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            guard(++n);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", 32'h0, s_axi_bresp);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            guard(++n);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check("rresp", 32'h0, s_axi_rresp);
    endtask : axi_read

    // Model keeps only what a write may legally change
    task automatic reg_write(input logic [7:0] a, input int d);
        if (a == OFF_RATE_SEL && d <= 8 || a == OFF_FRAME_SEL && d <= 3 || a == OFF_NODE_ADDR)
            model[a] = d;
        axi_write(a, d);
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a);
        logic [31:0] d;
        axi_read(a, d);
        check($sformatf("reg %0h", a), model[a], d);
    endtask : reg_check

    task automatic check_link();
        link_cfg_t e;
        int n;
        e.node_addr = 8'(model[OFF_NODE_ADDR]);
        e.baud = 17'(baud_tab[model[OFF_RATE_SEL]]);
        e.parity_en = model[OFF_FRAME_SEL] >= 2;
        e.parity_odd = model[OFF_FRAME_SEL] == 3;
        e.two_stop = model[OFF_FRAME_SEL] == 0;
        for (n = 0; n < 10 && link_cfg !== e; n++)
            @(posedge clk);
        check("link_cfg", e, link_cfg);
    endtask : check_link

    task automatic count_red(input int e);
        int r;
        r = 0;
        repeat (16 * FL)
        begin
            @(posedge clk);
            r += (status_lamp == LAMP_RED);
        end
        check("red cycles", e, r);
    endtask : count_red

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        model[OFF_MODULE_TYPE] = 32'hAA; // Arbitrary type value
        model[OFF_FW_MAJOR] = 32'h0;
        model[OFF_FW_MINOR] = 32'h0;
        model[OFF_NODE_ADDR] = 32'h1;
        model[OFF_RATE_SEL] = 32'h6;
        model[OFF_FRAME_SEL] = 32'h0;
        model[OFF_STATE_CODE] = 32'h4;
        model[OFF_DATA_FORMAT] = 32'hA22;
        model[8'h3C] = 32'h0;
    endtask : do_reset

    // ****
    // Main sequence
    // ****
    initial
    begin
        logic [31:0] d;
        link_cfg_t old;
        void'($urandom(92660));
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        mapping_error = 1'b0;
        mode = 4'h4;
        flags = 3'h0;
        fail_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        do_reset();
        check_link();
        check("rate match", 32'h1, rate_match);
        reg_write(OFF_MODULE_TYPE, 32'h55);
        foreach (model[k]) reg_check(8'(k));
        for (int c = 0; c < 10; c++)
        begin
            reg_write(OFF_RATE_SEL, c < 9 ? c : 9 + $urandom % 247);
            reg_write(OFF_FRAME_SEL, c % 5 < 4 ? c % 5 : 4 + $urandom % 252);
            reg_check(OFF_RATE_SEL);
            reg_check(OFF_FRAME_SEL);
            reg_write(OFF_CONTROL, 32'h1);
            check_link();
        end
        old = link_cfg;
        reg_write(OFF_NODE_ADDR, 2 + $urandom % 246);
        axi_read(OFF_STATUS, d);
        check("mismatch", 32'h1, d[2]);
        count_red(2 * FL);
        check("link held", old, link_cfg);
        reg_write(OFF_CONTROL, 32'h1);
        check_link();
        foreach (state_seq[i])
        begin
            mode <= 4'(state_seq[i]);
            model[OFF_STATE_CODE] = state_seq[i];
            reg_check(OFF_STATE_CODE);
            if (state_seq[i] == 0)
                check("status lamp", LAMP_OFF, status_lamp);
        end
        mode <= 4'h7;
        model[OFF_STATE_CODE] = 32'h7;
        reg_check(OFF_STATE_CODE);
        mode <= 4'h4;
        reg_check(OFF_STATE_CODE);
        check("net_enable", 32'h0, net_enable);
        check("status lamp", LAMP_RED, status_lamp);
        reg_write(OFF_CONTROL, 32'h2);
        model[OFF_STATE_CODE] = 32'h4;
        reg_check(OFF_STATE_CODE);
        check("net_enable", 32'h1, net_enable);
        check("status lamp", LAMP_GREEN, status_lamp);
        reg_write(OFF_CONTROL, 32'h8);
        count_red(4 * FL);
        reg_write(OFF_CONTROL, 32'h4);
        count_red(2 * FL);
        reg_write(OFF_CONTROL, 32'h10);
        mapping_error <= 1'b1;
        repeat (3) @(posedge clk);
        check("trip map", 32'h1, drive_trip);
        mapping_error <= 1'b0;
        mode <= 4'h5;
        repeat (3) @(posedge clk);
        check("trip bus", 32'h1, drive_trip);
        mode <= 4'h4;
        flags <= 3'h4;
        repeat (3) @(posedge clk);
        check("trip off", 32'h0, drive_trip);
        check("status lamp", LAMP_RED, status_lamp);
        flags <= 3'h1;
        repeat (3) @(posedge clk);
        check("comm lamp", LAMP_YELLOW, comm_lamp);
        flags <= 3'h0;
        repeat (3) @(posedge clk);
        check("comm lamp", LAMP_OFF, comm_lamp);
        flags <= 3'h2;
        repeat (3) @(posedge clk);
        check("comm lamp", LAMP_RED, comm_lamp);
        flags <= 3'h0;
        do_reset();
        check_link();
        check("comm lamp", LAMP_OFF, comm_lamp);
        reg_check(OFF_NODE_ADDR);
        report_and_stop();
    end
endmodule : tb_top
